/* File: dv/sdp_chk.sv */
/*
  checker watching the pin link between controller and memory ends.
  assumes it sits beside the link instance, link signals wired in.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sdp_defs.svh"
module sdp_chk #(
  parameter int PWRUP_CYC = 50
)(
  input wire logic        i_ref_clk,
  input wire logic        i_sys_rst,
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [1:0]  bank_select,
  input wire logic [12:0] addr,
  input wire logic        lower_byte_mask,
  input wire logic        upper_byte_mask,
  input wire logic [1:0]  dq_d_oe
);
  // ----------------------------------------
  // helpers: cycle age, first command, refresh tally
  // ----------------------------------------
  wire [3:0]   cmd_w  = {cs_n, ras_n, cas_n, we_n};
  wire         is_cmd = !cs_n && (cmd_w != `SDP_CMD_NOP);
  logic [15:0] cyc_q;  // saturates, only early cycles matter
  logic        seen_q; // any real command seen yet
  logic [1:0]  ref_q;  // refreshes seen, saturating
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cyc_q  <= 16'h0;
      seen_q <= 1'b0;
      ref_q  <= 2'h0;
    end else begin
      if (cyc_q != 16'hffff) cyc_q <= cyc_q + 16'h1;
      if (is_cmd) seen_q <= 1'b1;
      if (cmd_w == `SDP_CMD_REF && ref_q != 2'h3) ref_q <= ref_q + 2'h1;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // ----------------------------------------
  // link properties
  // ----------------------------------------
  AST_LOW_LANE_MASK: assert property (dq_d_oe[0] |-> !$past(lower_byte_mask, 3))
    else $error("low lane driven although masked");
  AST_HIGH_LANE_MASK: assert property (dq_d_oe[1] |-> !$past(upper_byte_mask, 3))
    else $error("high lane driven although masked");
  AST_READ_LATENCY: assert property ((cke && $past(cke) && cmd_w == `SDP_CMD_RD
    && !lower_byte_mask && !upper_byte_mask) |-> ##3 dq_d_oe == 2'h3)
    else $error("read data not driven at latency two");
  AST_WRITE_NO_DRIVE: assert property ((cmd_w == `SDP_CMD_WR) |-> ##3 dq_d_oe == 2'h0)
    else $error("memory drove bus after a write");
  AST_POWERUP_QUIET: assert property ((cyc_q < PWRUP_CYC - 1) |-> !is_cmd)
    else $error("command issued during power-up wait");
  AST_FIRST_PRECHARGE: assert property ((is_cmd && !seen_q) |->
    (cmd_w == `SDP_CMD_PRE && addr[10]))
    else $error("first command is not precharge all");
  AST_REFRESH_BEFORE_MODE: assert property ((cmd_w == `SDP_CMD_LMR) |-> ref_q >= 2'h2)
    else $error("mode load before two refreshes");
  AST_MODE_BANK_ZERO: assert property ((cmd_w == `SDP_CMD_LMR) |-> bank_select == 2'h0)
    else $error("mode load with nonzero bank");
endmodule // sdp_chk
`default_nettype wire

/* File: dv/test_sdram_pin_command_interface.sv */
/*
  self-checking bench: controller and memory ends joined by the link.
  assumes a 200 mhz clock and a shortened power-up wait.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sdp_defs.svh"
module test_sdram_pin_command_interface;
  localparam int PW = 50; // short power-up wait keeps the run brief
  logic        i_ref_clk   = 1'b0;
  logic        i_sys_rst   = 1'b1;
  logic        i_cmd_valid = 1'b0;
  logic [3:0]  i_cmd       = 4'h7;
  logic [1:0]  i_bank      = 2'h0;
  logic [12:0] i_addr      = 13'h0;
  logic [1:0]  i_dqm       = 2'h0;
  logic        i_wvalid    = 1'b0;
  logic [15:0] i_wdata     = 16'h0;
  logic        i_cke       = 1'b1;
  logic        o_ready, o_rvalid;
  logic [15:0] o_rdata;
  logic [4:0]  o_pwr_state;
  logic [14:0] o_mode;
  logic [3:0]  o_bank_open;
  logic [12:0] o_last_row;
  logic [7:0]  o_refresh_cnt;
  int          error_cnt   = 0;
  int          check_count = 0;
  // ----------------------------------------
  // both ends across one link
  // ----------------------------------------
  sdp_if pins();
  sdp_host #(.PWRUP_CYC(PW)) i_sdp_host (.i_ref_clk, .i_sys_rst, .pins, .i_cmd_valid, .i_cmd,
    .i_bank, .i_addr, .i_dqm, .i_wvalid, .i_wdata, .i_cke, .o_ready, .o_rvalid, .o_rdata);
  sdp_dev i_sdp_dev (.i_ref_clk, .i_sys_rst, .pins, .o_pwr_state, .o_mode, .o_bank_open,
    .o_last_row, .o_refresh_cnt);
  sdp_chk #(.PWRUP_CYC(PW)) i_sdp_chk (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .cke(pins.cke), .cs_n(pins.cs_n), .ras_n(pins.ras_n), .cas_n(pins.cas_n),
    .we_n(pins.we_n), .bank_select(pins.bank_select), .addr(pins.addr),
    .lower_byte_mask(pins.lower_byte_mask), .upper_byte_mask(pins.upper_byte_mask),
    .dq_d_oe(pins.dq_d_oe));
  always #2.5 i_ref_clk = ~i_ref_clk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic close_out;
    if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    check_count++;
    if (got !== ex) begin
      $display("wrong value %s expected %h seen %h", nm, ex, got);
      error_cnt++;
    end
  endtask
  task automatic wn(input int n);
    repeat (n) @(negedge i_ref_clk); // settled sampling point
  endtask
  // one user command; cke travels with it so entry can coincide
  task automatic go(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
                    input logic [1:0] m, input logic [15:0] d, input logic wv, input logic ck);
    @(posedge i_ref_clk);
    i_cmd <= c; i_bank <= b; i_addr <= a; i_dqm <= m;
    i_wdata <= d; i_wvalid <= wv; i_cke <= ck; i_cmd_valid <= 1'b1;
    @(posedge i_ref_clk);
    i_cmd_valid <= 1'b0;
  endtask
  // burst of eight words, mask held for the whole burst
  task automatic wr(input logic [12:0] a, input logic [1:0] m, input logic [15:0] d);
    go(`SDP_CMD_WR, 2'h2, a, m, d, 1'b1, 1'b1);
    wn(9);
    @(posedge i_ref_clk);
    i_wvalid <= 1'b0;
  endtask
  task automatic rd(input logic [12:0] a, input logic [1:0] m, input logic [15:0] keep,
                    input logic [15:0] ex);
    int k;
    go(`SDP_CMD_RD, 2'h2, a, m, 16'h0, 1'b0, 1'b1);
    for (k = 0; k < 20; k++) begin
      @(negedge i_ref_clk);
      if (o_rvalid === 1'b1) break;
    end
    chk("read valid", 16'h1, {15'h0, o_rvalid});
    chk("read lanes", {14'h0, ~m}, {14'h0, pins.dq_d_oe});
    chk("read data", ex & keep, o_rdata & keep);
    wn(12); // let the rest of the burst drain
  endtask
  // ----------------------------------------
  // watchdog and main sequence
  // ----------------------------------------
  initial begin
    #100000;
    error_cnt++;
    close_out();
  end
  initial begin
    int k;
    repeat (20) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    for (k = 0; k < 2000 && o_ready !== 1'b1; k++) @(negedge i_ref_clk);
    chk("refresh count", 16'h2, {8'h0, o_refresh_cnt});
    chk("mode", 16'h0023, {1'b0, o_mode});
    chk("power state", 16'h1, {11'h0, o_pwr_state});
    go(`SDP_CMD_ACT, 2'h2, 13'h1abc, 2'h0, 16'h0, 1'b0, 1'b1); wn(5);
    chk("row", 16'h1abc, {3'h0, o_last_row});
    chk("open banks", 16'h4, {12'h0, o_bank_open});
    go(4'hb, 2'h1, 13'h0555, 2'h0, 16'h0, 1'b0, 1'b1); wn(5); // deselected activate
    chk("deselected row", 16'h1abc, {3'h0, o_last_row});
    wr(13'h005, 2'h0, 16'ha5c3);
    wr(13'h005, 2'h1, 16'h1234);
    rd(13'h205, 2'h0, 16'hffff, 16'h12c3);
    rd(13'h005, 2'h2, 16'h00ff, 16'h00c3);
    rd(13'h405, 2'h0, 16'hffff, 16'h12c3);
    chk("auto precharge", 16'h0, {12'h0, o_bank_open});
    go(`SDP_CMD_ACT, 2'h0, 13'h0011, 2'h0, 16'h0, 1'b0, 1'b1);
    go(`SDP_CMD_ACT, 2'h3, 13'h0022, 2'h0, 16'h0, 1'b0, 1'b1);
    go(`SDP_CMD_PRE, 2'h0, 13'h0000, 2'h0, 16'h0, 1'b0, 1'b1); wn(5);
    chk("single precharge", 16'h8, {12'h0, o_bank_open});
    go(`SDP_CMD_PRE, 2'h1, 13'h0400, 2'h0, 16'h0, 1'b0, 1'b1); wn(5);
    chk("all precharge", 16'h0, {12'h0, o_bank_open});
    go(`SDP_CMD_REF, 2'h0, 13'h0000, 2'h0, 16'h0, 1'b0, 1'b1); wn(5);
    chk("refresh", 16'h3, {8'h0, o_refresh_cnt});
    go(`SDP_CMD_LMR, 2'h0, 13'h0020, 2'h0, 16'h0, 1'b0, 1'b1); wn(5);
    chk("mode load", 16'h0020, {1'b0, o_mode});
    go(`SDP_CMD_LMR, 2'h0, 13'h0023, 2'h0, 16'h0, 1'b0, 1'b1);
    go(`SDP_CMD_NOP, 2'h0, 13'h0000, 2'h0, 16'h0, 1'b0, 1'b0); wn(6);
    chk("precharge pd", 16'h8, {11'h0, o_pwr_state});
    go(`SDP_CMD_ACT, 2'h1, 13'h0033, 2'h0, 16'h0, 1'b0, 1'b0); wn(5);
    chk("pd ignores", 16'h0, {12'h0, o_bank_open});
    go(`SDP_CMD_NOP, 2'h0, 13'h0000, 2'h0, 16'h0, 1'b0, 1'b1); wn(6);
    chk("pd exit", 16'h1, {11'h0, o_pwr_state});
    go(`SDP_CMD_ACT, 2'h1, 13'h0033, 2'h0, 16'h0, 1'b0, 1'b1); wn(4);
    go(`SDP_CMD_NOP, 2'h0, 13'h0000, 2'h0, 16'h0, 1'b0, 1'b0); wn(6);
    chk("active pd", 16'h4, {11'h0, o_pwr_state});
    go(`SDP_CMD_NOP, 2'h0, 13'h0000, 2'h0, 16'h0, 1'b0, 1'b1); // wake first
    go(`SDP_CMD_PRE, 2'h0, 13'h0400, 2'h0, 16'h0, 1'b0, 1'b1); wn(6);
    go(`SDP_CMD_REF, 2'h0, 13'h0000, 2'h0, 16'h0, 1'b0, 1'b0); wn(6);
    chk("self refresh", 16'h10, {11'h0, o_pwr_state});
    go(`SDP_CMD_NOP, 2'h0, 13'h0000, 2'h0, 16'h0, 1'b0, 1'b1); wn(8);
    chk("self refresh exit", 16'h1, {11'h0, o_pwr_state});
    close_out();
  end
endmodule // test_sdram_pin_command_interface
`default_nettype wire

/* File: hdl/sdp_defs.svh */
/*
  constants for the sdram pin command interface: strobe codes, address
  field positions, mode register fields and timing counts.
  assumes a 200 mhz reference clock shared by both ends.
*/
`ifndef SDP_DEFS_SVH
`define SDP_DEFS_SVH

// ----------------------------------------------------------------
// strobe codes {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------------------------------
`define SDP_CMD_LMR   4'h0
`define SDP_CMD_REF   4'h1
`define SDP_CMD_PRE   4'h2
`define SDP_CMD_ACT   4'h3
`define SDP_CMD_WR    4'h4
`define SDP_CMD_RD    4'h5
`define SDP_CMD_BST   4'h6
`define SDP_CMD_NOP   4'h7
`define SDP_CMD_INH   4'hf

// ----------------------------------------------------------------
// widths and field positions
// ----------------------------------------------------------------
`define SDP_ADDR_W    13
`define SDP_COL_W     9
`define SDP_BANKS     4
`define SDP_AP_BIT    10
`define SDP_MEM_IDX_W 4
`define SDP_MODE_W    15
`define SDP_MODE_BL_LO 0
`define SDP_MODE_CL_LO 4
`define SDP_BL_FULL   3'h7
`define SDP_PAGE_LEN  10'h200
`define SDP_CL_TWO    3'h2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SDP_CLK_NS     5
`define SDP_PWRUP_NS   100000
`define SDP_PWRUP_CYC  ((`SDP_PWRUP_NS + `SDP_CLK_NS - 1) / `SDP_CLK_NS)
`define SDP_INIT_GAP   5'h10
`define SDP_MODE_INIT  15'h0023

`endif

/* File: hdl/sdp_dev.sv */
/*
  memory end of the sdram pin interface: input capture, clock-enable
  states, command decode, bank/row/column addressing, bursts, byte masks.
  assumes the controller drives the pins from flops on the same clock,
  so no synchroniser is needed; a small array stands for the cell array.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sdp_defs.svh"
module sdp_dev
  import sdp_pkg::*;
(
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_sys_rst,
  sdp_if.dev                          pins,
  output logic     [4:0]              o_pwr_state,
  output logic     [`SDP_MODE_W-1:0]  o_mode,
  output logic     [`SDP_BANKS-1:0]   o_bank_open,
  output logic     [`SDP_ADDR_W-1:0]  o_last_row,
  output logic     [7:0]              o_refresh_cnt
);
  // ----------------------------------------------------------------
  // input capture
  // ----------------------------------------------------------------
  logic                   cke_q;    // sampled clock enable
  logic [3:0]             cmd_q;    // sampled strobes
  logic [1:0]             ba_q;     // sampled bank select
  logic [`SDP_ADDR_W-1:0] a_q;      // sampled address
  logic [1:0]             dqm_q;    // sampled byte masks
  logic [15:0]            din_q;    // sampled write data
  sdp_pwr_t               pwr_q;    // clock-enable state
  sdp_pwr_t               pwr_d;

  // every pin is taken only on the rising edge
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cke_q <= 1'b0;
      cmd_q <= `SDP_CMD_INH;
      ba_q  <= 2'h0;
      a_q   <= 13'h0000;
      dqm_q <= 2'h3;
      din_q <= 16'h0000;
    end else if (pwr_q == SDP_RUN || pwr_q == SDP_SUSP) begin
      cke_q <= pins.cke;
      cmd_q <= {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
      ba_q  <= pins.bank_select;
      a_q   <= pins.addr;
      dqm_q <= {pins.upper_byte_mask, pins.lower_byte_mask};
      din_q <= pins.data_lines;
    end else begin
      // input buffers off: a clean deselect is seen after wake-up
      cke_q <= 1'b1;
      cmd_q <= `SDP_CMD_INH;
    end
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic        tick;       // internal clock runs this cycle
  logic        sel;        // decoder enabled
  logic        is_act, is_rd, is_wr, is_pre, is_ref, is_lmr, is_bst;
  logic        burst_q;    // burst in progress
  logic        bwr_q;      // burst is a write
  logic        ap_q;       // auto precharge at burst end
  logic [1:0]  bbank_q;    // burst bank
  logic [`SDP_COL_W-1:0] col_q;   // burst column counter
  logic [9:0]  left_q;     // beats left after current
  logic [`SDP_MODE_W-1:0] mode_q;
  logic [`SDP_BANKS-1:0]  open_q;
  logic [2:0]  bl_code;
  logic [9:0]  bl_len;
  logic        cl_two;

  assign tick    = (pwr_q == SDP_RUN) && cke_q;
  assign sel     = tick && !cmd_q[3];
  assign is_act  = sel && (cmd_q == `SDP_CMD_ACT);
  assign is_rd   = sel && (cmd_q == `SDP_CMD_RD);
  assign is_wr   = sel && (cmd_q == `SDP_CMD_WR);
  assign is_pre  = sel && (cmd_q == `SDP_CMD_PRE);
  assign is_ref  = sel && (cmd_q == `SDP_CMD_REF);
  assign is_lmr  = sel && (cmd_q == `SDP_CMD_LMR);
  assign is_bst  = sel && (cmd_q == `SDP_CMD_BST);
  assign bl_code = mode_q[`SDP_MODE_BL_LO +: 3];
  assign cl_two  = (mode_q[`SDP_MODE_CL_LO +: 3] == `SDP_CL_TWO);
  // burst length from the mode field; unknown codes fall to one
  assign bl_len  = (bl_code == `SDP_BL_FULL) ? `SDP_PAGE_LEN :
                   (bl_code < 3'h4) ? (10'h001 << bl_code) : 10'h001;

  // ----------------------------------------------------------------
  // clock-enable states
  // ----------------------------------------------------------------
  // entry uses the sampled level; exit from the deep states looks at the
  // live pin since the clock input there is treated as off
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      SDP_RUN: begin
        if (!cke_q) begin
          if (!cmd_q[3] && cmd_q == `SDP_CMD_REF && open_q == 4'h0)
            pwr_d = SDP_SREF;
          else if (burst_q)
            pwr_d = SDP_SUSP;
          else if (open_q != 4'h0)
            pwr_d = SDP_APD;
          else
            pwr_d = SDP_PPD;
        end
      end
      SDP_SUSP: begin
        if (pins.cke) pwr_d = SDP_RUN;    // synchronous exit
      end
      SDP_APD, SDP_PPD, SDP_SREF: begin
        if (pins.cke) pwr_d = SDP_RUN;
      end
      default: pwr_d = SDP_RUN;
    endcase
  end

  // state register
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) pwr_q <= SDP_RUN;
    else           pwr_q <= pwr_d;
  end

  // ----------------------------------------------------------------
  // mode, rows, refresh count
  // ----------------------------------------------------------------
  // op-code comes from bank select and address together
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      mode_q        <= `SDP_MODE_INIT;
      o_last_row    <= 13'h0000;
      o_refresh_cnt <= 8'h00;
    end else begin
      if (is_lmr) mode_q <= {ba_q, a_q};
      if (is_act) o_last_row <= a_q;
      if (is_ref) o_refresh_cnt <= o_refresh_cnt + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // bank open flags, one per bank
  // ----------------------------------------------------------------
  logic burst_end;   // last beat of current burst
  assign burst_end = tick && burst_q && (left_q == 10'h000);

  logic [`SDP_BANKS-1:0] open_d;   // next open flags, one per bank

  genvar gb;
  generate
    for (gb = 0; gb < `SDP_BANKS; gb++) begin : g_bank
      logic hit;    // command targets this bank
      assign hit = (ba_q == 2'(gb));
      assign open_d[gb] = (is_act && hit) ? 1'b1 :
                          (is_pre && (a_q[`SDP_AP_BIT] || hit)) ? 1'b0 :
                          (burst_end && ap_q && bbank_q == 2'(gb)) ? 1'b0 :
                          open_q[gb];
    end
  endgenerate

  // one register holds all flags so each bit has a single driver
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) open_q <= 4'h0;
    else           open_q <= open_d;
  end

  // ----------------------------------------------------------------
  // burst counter
  // ----------------------------------------------------------------
  logic                  start;     // read or write starts a burst
  logic [`SDP_COL_W-1:0] beat_col;  // column of this beat
  logic [1:0]            beat_bank;
  logic                  beat_wr, beat_rd;
  assign start     = is_rd || is_wr;
  assign beat_col  = start ? a_q[`SDP_COL_W-1:0] : col_q;
  assign beat_bank = start ? ba_q : bbank_q;
  assign beat_wr   = is_wr || (tick && burst_q && bwr_q && !is_bst && !start);
  assign beat_rd   = is_rd || (tick && burst_q && !bwr_q && !is_bst && !start);

  // advances on every running clock, even with chip select high
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      burst_q <= 1'b0;
      bwr_q   <= 1'b0;
      ap_q    <= 1'b0;
      bbank_q <= 2'h0;
      col_q   <= 9'h000;
      left_q  <= 10'h000;
    end else if (start) begin          // new read or write cuts an old burst
      burst_q <= (bl_len != 10'h001);
      bwr_q   <= is_wr;
      ap_q    <= a_q[`SDP_AP_BIT];
      bbank_q <= ba_q;
      col_q   <= a_q[`SDP_COL_W-1:0] + 9'h001;
      left_q  <= bl_len - 10'h002;
    end else if (is_bst || burst_end) begin
      burst_q <= 1'b0;
    end else if (tick && burst_q) begin
      col_q  <= col_q + 9'h001;
      left_q <= left_q - 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // storage, one array per byte lane
  // ----------------------------------------------------------------
  // only the low column bits are kept; a full array is out of scope
  logic [`SDP_MEM_IDX_W+1:0] idx;
  logic [15:0]               rword;
  assign idx = {beat_bank, beat_col[`SDP_MEM_IDX_W-1:0]};

  genvar gl;
  generate
    for (gl = 0; gl < 2; gl++) begin : g_lane
      logic [7:0] mem [0:(1 << (`SDP_MEM_IDX_W + 2)) - 1];
      assign rword[gl*8 +: 8] = mem[idx];
      // a high mask on this lane keeps the old byte
      always_ff @(posedge i_ref_clk) begin
        if (beat_wr && !dqm_q[gl]) mem[idx] <= din_q[gl*8 +: 8];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // read pipeline and output registers
  // ----------------------------------------------------------------
  logic [15:0] rp_q;    // first latency stage data
  logic        rv_q;    // first latency stage valid
  logic [15:0] rp2_q;
  logic        rv2_q;
  logic [1:0]  mp_q;    // mask one clock after sampling
  logic [15:0] out_w;
  logic        outv_w;
  assign out_w  = cl_two ? rp_q : rp2_q;
  assign outv_w = cl_two ? rv_q : rv2_q;

  // stages hold still while the clock is suspended
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      rp_q         <= 16'h0000;
      rv_q         <= 1'b0;
      rp2_q        <= 16'h0000;
      rv2_q        <= 1'b0;
      mp_q         <= 2'h3;
      pins.dq_d    <= 16'h0000;
      pins.dq_d_oe <= 2'h0;
    end else if (tick) begin
      rp_q         <= rword;
      rv_q         <= beat_rd;
      rp2_q        <= rp_q;
      rv2_q        <= rv_q;
      mp_q         <= dqm_q;
      pins.dq_d    <= out_w;
      pins.dq_d_oe <= {2{outv_w}} & ~mp_q;
    end else if (pwr_q != SDP_SUSP) begin
      pins.dq_d_oe <= 2'h0;     // outputs float in power-down
    end
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_pwr_state <= SDP_RUN;
      o_mode      <= `SDP_MODE_INIT;
      o_bank_open <= 4'h0;
    end else begin
      o_pwr_state <= pwr_q;
      o_mode      <= mode_q;
      o_bank_open <= open_q;
    end
  end
endmodule // sdp_dev
`default_nettype wire

/* File: hdl/sdp_host.sv */
/*
  controller end of the sdram pin interface: power-up wait, the
  precharge / refresh / mode-load start-up, then user commands to pins.
  assumes the memory shares the reference clock; all pins from flops.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sdp_defs.svh"
module sdp_host
  import sdp_pkg::*;
#(
  parameter int PWRUP_CYC = `SDP_PWRUP_CYC
)(
  input  wire logic        i_ref_clk,
  input  wire logic        i_sys_rst,
  sdp_if.host              pins,
  input  wire logic        i_cmd_valid,
  input  wire logic [3:0]  i_cmd,
  input  wire logic [1:0]  i_bank,
  input  wire logic [12:0] i_addr,
  input  wire logic [1:0]  i_dqm,
  input  wire logic        i_wvalid,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_cke,
  output logic             o_ready,
  output logic             o_rvalid,
  output logic      [15:0] o_rdata
);
  // ----------------------------------------------------------------
  // start-up sequencer
  // ----------------------------------------------------------------
  sdp_hst_t    st_q;     // sequence state
  logic [14:0] wait_q;   // power-up counter
  logic [4:0]  gap_q;    // spacing counter
  logic [1:0]  step_q;   // 0 pre-all, 1/2 refresh, 3 mode load
  logic        wait_done;
  logic [3:0]  init_cmd;
  assign wait_done = (wait_q == 15'(PWRUP_CYC - 1));
  assign init_cmd  = (step_q == 2'h0) ? `SDP_CMD_PRE :
                     (step_q == 2'h3) ? `SDP_CMD_LMR : `SDP_CMD_REF;

  // walk: wait, then issue and space the four start-up commands
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      st_q   <= SDP_H_PWR;
      wait_q <= 15'h0000;
      gap_q  <= 5'h00;
      step_q <= 2'h0;
    end else begin
      case (st_q)
        SDP_H_PWR: begin
          wait_q <= wait_q + 15'h0001;
          if (wait_done) st_q <= SDP_H_ISSUE;
        end
        SDP_H_ISSUE: begin
          gap_q <= 5'h00;
          st_q  <= SDP_H_GAP;
        end
        SDP_H_GAP: begin
          gap_q <= gap_q + 5'h01;
          if (gap_q == `SDP_INIT_GAP) begin
            step_q <= step_q + 2'h1;
            st_q   <= (step_q == 2'h3) ? SDP_H_READY : SDP_H_ISSUE;
          end
        end
        SDP_H_READY: st_q <= SDP_H_READY;
        default:     st_q <= SDP_H_PWR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  logic       rdy;
  logic [3:0] ucmd;    // user command or no-op
  assign rdy  = (st_q == SDP_H_READY);
  assign ucmd = i_cmd_valid ? i_cmd : `SDP_CMD_NOP;

  // only no-ops during the wait; start-up values otherwise
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      pins.cke         <= 1'b0;
      {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= `SDP_CMD_INH;
      pins.bank_select <= 2'h0;
      pins.addr        <= 13'h0000;
      {pins.upper_byte_mask, pins.lower_byte_mask} <= 2'h3;
      pins.dq_h        <= 16'h0000;
      pins.dq_h_oe     <= 2'h0;
    end else if (rdy) begin
      pins.cke         <= i_cke;
      {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= ucmd;
      pins.bank_select <= i_bank;
      pins.addr        <= i_addr;
      {pins.upper_byte_mask, pins.lower_byte_mask} <= i_dqm;
      pins.dq_h        <= i_wdata;
      pins.dq_h_oe     <= {2{i_wvalid}};
    end else begin
      pins.cke <= (wait_q[14:1] != 14'h0000) || (st_q != SDP_H_PWR);
      {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <=
        (st_q == SDP_H_ISSUE) ? init_cmd : `SDP_CMD_NOP;
      pins.bank_select <= 2'h0;
      // all-bank flag on precharge, op-code on mode load
      pins.addr <= (step_q == 2'h3) ? 13'(`SDP_MODE_INIT) : 13'h0400;
      pins.dq_h_oe <= 2'h0;
    end
  end

  // ----------------------------------------------------------------
  // user side status and read capture
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_ready  <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata  <= 16'h0000;
    end else begin
      o_ready  <= rdy;
      o_rvalid <= |pins.dq_d_oe;
      o_rdata  <= pins.dq_d;
    end
  end
endmodule // sdp_host
`default_nettype wire

/* File: hdl/sdp_if.sv */
/*
  pin-level link between the memory controller and the sdram.
  assumes both ends run on the same reference clock; the shared data
  bus level is resolved here from the two enable groups.
*/
`timescale 1ns/1ps
`default_nettype none
interface sdp_if;
  logic        cke;       // clock enable
  logic        cs_n;      // chip select, low active
  logic        ras_n;     // row strobe, low active
  logic        cas_n;     // column strobe, low active
  logic        we_n;      // write strobe, low active
  logic [1:0]  bank_select;
  logic [12:0] addr;
  logic        lower_byte_mask;
  logic        upper_byte_mask;
  logic [15:0] dq_h;      // controller drive value
  logic [1:0]  dq_h_oe;   // controller lane enables
  logic [15:0] dq_d;      // memory drive value
  logic [1:0]  dq_d_oe;   // memory lane enables
  wire  [15:0] data_lines;

  // byte-lane resolution of the shared data bus; a lane nobody drives
  // reads as the pull-up level, so stale data is never mistaken for input
  assign data_lines[7:0]  = dq_d_oe[0] ? dq_d[7:0]  : dq_h_oe[0] ? dq_h[7:0]  : 8'hff;
  assign data_lines[15:8] = dq_d_oe[1] ? dq_d[15:8] : dq_h_oe[1] ? dq_h[15:8] : 8'hff;

  modport dev (input cke, cs_n, ras_n, cas_n, we_n, bank_select, addr,
               lower_byte_mask, upper_byte_mask, data_lines,
               output dq_d, dq_d_oe);
  modport host (output cke, cs_n, ras_n, cas_n, we_n, bank_select, addr,
                lower_byte_mask, upper_byte_mask, dq_h, dq_h_oe,
                input dq_d, dq_d_oe);
endinterface
`default_nettype wire

/* File: hdl/sdp_pkg.sv */
/*
  types shared by both ends of the sdram pin interface.
  assumes sdp_defs.svh is on the include path.
*/
`default_nettype none
`include "sdp_defs.svh"
package sdp_pkg;
  // command decoded from the strobes
  typedef enum logic [3:0] {
    SDP_LMR = `SDP_CMD_LMR,
    SDP_REF = `SDP_CMD_REF,
    SDP_PRE = `SDP_CMD_PRE,
    SDP_ACT = `SDP_CMD_ACT,
    SDP_WR  = `SDP_CMD_WR,
    SDP_RD  = `SDP_CMD_RD,
    SDP_BST = `SDP_CMD_BST,
    SDP_NOP = `SDP_CMD_NOP,
    SDP_INH = `SDP_CMD_INH
  } sdp_cmd_t;
  // device clock-enable states, one-hot
  typedef enum logic [4:0] {
    SDP_RUN  = 5'h01,
    SDP_SUSP = 5'h02,
    SDP_APD  = 5'h04,
    SDP_PPD  = 5'h08,
    SDP_SREF = 5'h10
  } sdp_pwr_t;
  // controller sequence states, one-hot
  typedef enum logic [3:0] {
    SDP_H_PWR   = 4'h1,
    SDP_H_ISSUE = 4'h2,
    SDP_H_GAP   = 4'h4,
    SDP_H_READY = 4'h8
  } sdp_hst_t;
endpackage
`default_nettype wire
